// [common/laser_pkg.sv]
// Package: register map, field layout, timing and carrier types for the laser safety block
package laser_pkg;
    localparam logic [7:0] OFS_CTRL_PRIMARY = 8'h1A; // Range, calibration enable
    localparam logic [7:0] OFS_CURRENT_CODE = 8'h1C; // Laser current code
    localparam logic [7:0] OFS_CURRENT_INV = 8'h1D; // Complement of current code
    localparam logic [7:0] OFS_CTRL_COMPLEMENT = 8'h1F; // Complement of range field
    localparam int RANGE_HI = 7; // Range field top bit
    localparam int RANGE_LO = 6; // Range field bottom bit
    localparam int CAL_HI = 3; // Calibration field top bit
    localparam int CAL_LO = 1; // Calibration field bottom bit
    localparam logic [7:0] CTRL_RESET = 8'h00; // Control reset value
    localparam logic [7:0] CODE_RESET = 8'h00; // Current code reset value
    localparam logic [7:0] INV_RESET = 8'hFF; // Inverse code reset value
    localparam logic [7:0] CTRL_C_RESET = 8'hC0; // Complement reset value
    localparam int CLK_MHZ = 25; // System clock rate
    localparam int PULSE_PERIOD_US = 10; // Pulsed drive period
    localparam int PULSE_ON_US = 1; // Pulsed drive on time
    localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_US * CLK_MHZ; // Period in cycles
    localparam int PULSE_ON_CYC = PULSE_ON_US * CLK_MHZ; // On time in cycles
    localparam int TEST_PERIOD_US = 40; // Self-test interval
    localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * CLK_MHZ; // Interval in cycles
    localparam int TEST_SETTLE_CYC = 4; // Cycles pin held low before check

    // Register write request from the serial port
    typedef struct packed {
        logic       wr;   // Write strobe
        logic [7:0] addr; // Register offset
        logic [7:0] data; // Write data
    } reg_req_t;

    // Self-test sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_PULL, ST_CHECK} test_state_t;
endpackage

// [logic/laser_power_fault_control.sv]
// Laser drive control with single-fault detection and continuous self-test
module laser_power_fault_control
    import laser_pkg::*;
(
    input wire logic sys_clk, // System clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire laser_pkg::reg_req_t req, // Register write request
    input wire logic [7:0] rd_addr, // Register read offset
    output logic [7:0] rd_data, // Registered read data
    input wire logic laser_fault_sense_pin_i, // Sense pin level in
    output logic laser_fault_sense_pin_o, // Sense pin drive value
    output logic laser_fault_sense_pin_oe, // Sense pin pull-down enable
    output logic laser_supply_enable_n, // Laser supply enable, active low
    output logic laser_drive_on, // Current source on
    output logic [7:0] laser_drive_code, // Current code to source
    output logic [1:0] laser_drive_range, // Range to source
    output logic fault_flag // Latched fault status
);
    import laser_pkg::*;

    logic [7:0] ctrl_reg, ctrl_next; // Primary control
    logic [7:0] code_reg, code_next; // Current code
    logic [7:0] inv_reg, inv_next; // Inverse code
    logic [7:0] ctrl_c_reg, ctrl_c_next; // Complement control
    logic [7:0] rd_reg, rd_next; // Read data
    logic fault_reg, fault_next; // Latched fault
    logic [8:0] pulse_cnt_reg, pulse_cnt_next; // Pulse period counter
    logic [10:0] test_cnt_reg, test_cnt_next; // Self-test interval counter
    logic [2:0] settle_reg, settle_next; // Pull settle counter
    test_state_t test_reg, test_next; // Self-test state
    logic drive_reg, drive_next; // Drive on
    logic cal_mode; // Calibration enabled
    logic ground_fault; // Pin pulled to ground externally
    logic test_fail; // Self-test saw pin high
    logic supply_enable_n_next; // Supply enable next, high cuts supply
    logic pull_en_next; // Pull-down enable next

    // Calibration enabled by any bit of field
    assign cal_mode = |ctrl_reg[CAL_HI:CAL_LO];
    // External short to ground while not self-testing
    assign ground_fault = (test_reg == ST_IDLE) && !laser_fault_sense_pin_i;
    // Pin fails to follow internal pull-down
    assign test_fail = (test_reg == ST_CHECK) && laser_fault_sense_pin_i;

    // Register file next values
    always_comb begin
        ctrl_next = ctrl_reg;
        code_next = code_reg;
        inv_next = inv_reg;
        ctrl_c_next = ctrl_c_reg;
        if (req.wr) begin
            // Decode write offset
            case (req.addr)
                OFS_CTRL_PRIMARY: ctrl_next = req.data;
                OFS_CURRENT_CODE: code_next = req.data;
                OFS_CURRENT_INV: inv_next = req.data;
                OFS_CTRL_COMPLEMENT: ctrl_c_next = req.data;
                default: ;
            endcase
        end
        // Read mux, unmapped reads zero
        case (rd_addr)
            OFS_CTRL_PRIMARY: rd_next = ctrl_reg;
            OFS_CURRENT_CODE: rd_next = code_reg;
            OFS_CURRENT_INV: rd_next = inv_reg;
            OFS_CTRL_COMPLEMENT: rd_next = ctrl_c_reg;
            default: rd_next = 8'h00;
        endcase
    end

    // Register file storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            code_reg <= CODE_RESET;
            inv_reg <= INV_RESET;
            ctrl_c_reg <= CTRL_C_RESET;
            rd_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            code_reg <= code_next;
            inv_reg <= inv_next;
            ctrl_c_reg <= ctrl_c_next;
            rd_reg <= rd_next;
        end
    end

    // Self-test sequencer and fault latch
    always_comb begin
        test_next = test_reg;
        test_cnt_next = test_cnt_reg;
        settle_next = settle_reg;
        fault_next = fault_reg || ground_fault || test_fail;
        case (test_reg)
            ST_IDLE: begin
                // Wait for next test slot
                if (test_cnt_reg == 11'(TEST_PERIOD_CYC - 1)) begin
                    test_cnt_next = 11'h000;
                    settle_next = 3'h0;
                    test_next = ST_PULL;
                end else begin
                    test_cnt_next = test_cnt_reg + 11'h001;
                end
            end
            ST_PULL: begin
                // Laser off, pin pulled low, let it settle
                if (settle_reg == 3'(TEST_SETTLE_CYC - 1)) begin
                    test_next = ST_CHECK;
                end else begin
                    settle_next = settle_reg + 3'h1;
                end
            end
            ST_CHECK: test_next = ST_IDLE; // One-cycle sample
            default: test_next = ST_IDLE;
        endcase
    end

    // Self-test registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            test_reg <= ST_IDLE;
            test_cnt_reg <= 11'h000;
            settle_reg <= 3'h0;
            fault_reg <= 1'h0;
        end else begin
            test_reg <= test_next;
            test_cnt_reg <= test_cnt_next;
            settle_reg <= settle_next;
            fault_reg <= fault_next;
        end
    end

    // Drive timing: pulsed or continuous
    always_comb begin
        if (pulse_cnt_reg == 9'(PULSE_PERIOD_CYC - 1)) begin
            pulse_cnt_next = 9'h000;
        end else begin
            pulse_cnt_next = pulse_cnt_reg + 9'h001;
        end
        if (fault_next || test_next != ST_IDLE) begin
            drive_next = 1'h0;
        end else if (cal_mode) begin
            drive_next = 1'h1;
        end else begin
            drive_next = (pulse_cnt_next < 9'(PULSE_ON_CYC));
        end
    end

    // Drive registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pulse_cnt_reg <= 9'h000;
            drive_reg <= 1'h0;
        end else begin
            pulse_cnt_reg <= pulse_cnt_next;
            drive_reg <= drive_next;
        end
    end

    // Output next values
    always_comb begin
        // Supply cut on fault or during test
        supply_enable_n_next = fault_next || (test_next != ST_IDLE);
        // Pin pulled low only while testing
        pull_en_next = (test_next != ST_IDLE);
    end

    // Outputs, all from flip-flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            laser_supply_enable_n <= 1'h0;
            laser_fault_sense_pin_oe <= 1'h0;
            laser_fault_sense_pin_o <= 1'h0;
            laser_drive_code <= 8'h00;
            laser_drive_range <= 2'h0;
            fault_flag <= 1'h0;
        end else begin
            laser_supply_enable_n <= supply_enable_n_next;
            laser_fault_sense_pin_oe <= pull_en_next;
            laser_fault_sense_pin_o <= 1'h0;
            laser_drive_code <= code_reg;
            laser_drive_range <= ctrl_reg[RANGE_HI:RANGE_LO];
            fault_flag <= fault_next;
        end
    end
    assign rd_data = rd_reg;
    assign laser_drive_on = drive_reg;

    // Latched fault holds supply off
    a_fault_holds_off: assert property (@(posedge sys_clk) disable iff (rst)
        fault_flag |=> fault_flag && laser_supply_enable_n && !laser_drive_on)
        else $error("fault did not hold laser off");
    // Ground at pin raises fault next cycle
    a_ground_trips: assert property (@(posedge sys_clk) disable iff (rst)
        ground_fault |=> fault_flag && laser_supply_enable_n)
        else $error("ground fault not caught");
    // Calibration gives continuous drive
    a_cal_continuous: assert property (@(posedge sys_clk) disable iff (rst)
        cal_mode && !fault_next && test_next == ST_IDLE |=> laser_drive_on)
        else $error("calibration drive not continuous");
    // Self-test failure latches fault
    a_test_fail: assert property (@(posedge sys_clk) disable iff (rst)
        test_fail |=> fault_flag)
        else $error("self-test failure not reported");
    // Enable low when healthy and idle
    a_enable_low: assert property (@(posedge sys_clk) disable iff (rst)
        !fault_next && test_next == ST_IDLE |=> !laser_supply_enable_n)
        else $error("supply enable high without cause");
    // Pulsed drive off outside the on slot
    a_pulse_off: assert property (@(posedge sys_clk) disable iff (rst)
        !cal_mode && pulse_cnt_next >= 9'(PULSE_ON_CYC) |=> !laser_drive_on)
        else $error("pulsed drive on outside its slot");
    // Self-test window: pin pulled, supply cut, drive off
    sequence s_test_window;
        laser_fault_sense_pin_oe && laser_supply_enable_n && !laser_drive_on;
    endsequence
    // Pull-down released after the check cycle
    sequence s_test_release;
        !laser_fault_sense_pin_oe;
    endsequence
    // Four settle cycles plus one check, then release
    a_test_window: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(laser_fault_sense_pin_oe) |-> s_test_window [*5] ##1 s_test_release)
        else $error("self-test window wrong");
endmodule

// [tb/mcu_model.sv]
// Controller model: register writes for calibration and restore
module mcu_model
    import laser_pkg::*;
(
    input wire logic sys_clk, // System clock
    output laser_pkg::reg_req_t req // Write request
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] nv [4]; // Saved settings: ctrl, code, inverse, complement
    initial req = '0;
    // One-cycle strobe launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req <= '{1'h1, a, d};
        @(negedge sys_clk);
        req <= '0;
    endtask
    // Ramp in low range, optionally again in high range; keep the last values
    task automatic calibrate(input logic [7:0] top, input logic hi);
        logic [1:0] rng;
        rng = 2'b01;
        for (int p = 0; p <= int'(hi); p++) begin
            nv = '{{rng, 6'h0E}, 8'h00, 8'hFF, {~rng, 6'h00}};
            wr(OFS_CTRL_PRIMARY, nv[0]);
            wr(OFS_CTRL_COMPLEMENT, nv[3]);
            for (int c = 0; c <= top; c++) begin
                nv[1] = 8'(c);
                nv[2] = ~nv[1];
                wr(OFS_CURRENT_CODE, nv[1]);
                wr(OFS_CURRENT_INV, nv[2]);
            end
            rng = 2'b10;
        end
    endtask
    // Rewrite all saved settings after a reset
    task automatic restore();
        wr(OFS_CTRL_PRIMARY, nv[0]);
        wr(OFS_CURRENT_CODE, nv[1]);
        wr(OFS_CURRENT_INV, nv[2]);
        wr(OFS_CTRL_COMPLEMENT, nv[3]);
    endtask
endmodule

// [tb/tb_laser_power_fault_control.sv]
// Testbench: registers, drive modes, ground fault and self-test fault
module tb_laser_power_fault_control;
    timeunit 1ns;
    timeprecision 1ns;
    import laser_pkg::*;
    logic sys_clk, rst, pin_i, pin_o, pin_oe, en_n, drv_on, flag, gnd, vdd;
    reg_req_t req; // Write request from the controller model
    logic [7:0] rd_addr, rd_data, drv_code;
    logic [1:0] drv_range, rng;
    int num_errors = 0, checked = 0, cycles = 0, seed = 54845, n_on, n_off;
    logic [7:0] top;
    // Sense pin: shorts win, else self-test pull-down, else pulled up
    assign pin_i = vdd | ~(gnd | (pin_oe & ~pin_o));
    laser_power_fault_control dut (.sys_clk(sys_clk), .rst(rst), .req(req),
        .rd_addr(rd_addr), .rd_data(rd_data), .laser_fault_sense_pin_i(pin_i),
        .laser_fault_sense_pin_o(pin_o), .laser_fault_sense_pin_oe(pin_oe),
        .laser_supply_enable_n(en_n), .laser_drive_on(drv_on),
        .laser_drive_code(drv_code), .laser_drive_range(drv_range), .fault_flag(flag));
    mcu_model mcu (.sys_clk(sys_clk), .req(req));
    // Clock, 40 ns period
    initial begin
        sys_clk = 0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    function automatic logic [7:0] exp_ctrl(input logic [1:0] r);
        return {r, 6'h0E};
    endfunction
    function automatic logic [7:0] exp_comp(input logic [1:0] r);
        return {~r, 6'h00};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Read one register; data is registered one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        rd_addr = a;
        @(negedge sys_clk);
        check("rd_data", rd_data, exp);
    endtask
    // Count drive-on and supply-off cycles over one pulse period
    task automatic sample();
        n_on = 0;
        n_off = 0;
        repeat (PULSE_PERIOD_CYC) begin
            @(negedge sys_clk);
            n_on += int'(drv_on === 1'b1);
            n_off += int'(en_n !== 1'b0);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        rst = 1;
        rd_addr = 8'h00;
        gnd = 0;
        vdd = 0;
        repeat (8) @(negedge sys_clk);
        rst = 0;
        rd(OFS_CTRL_PRIMARY, CTRL_RESET);
        rd(OFS_CURRENT_INV, INV_RESET);
        rd(OFS_CTRL_COMPLEMENT, CTRL_C_RESET);
        rd(8'h1E, 8'h00);
        mcu.wr(OFS_CTRL_PRIMARY, 8'h40);
        sample();
        check("pulsed", 8'(n_on > 0 && n_on <= PULSE_ON_CYC), 8'h01);
        check("enable_n", 8'(n_off <= TEST_SETTLE_CYC + 1), 8'h01);
        for (int t = 0; t < 3; t++) begin
            top = 8'($random(seed)) & 8'h0F;
            mcu.calibrate(top, t[0]);
            rng = t[0] ? 2'b10 : 2'b01;
            rd(OFS_CTRL_PRIMARY, exp_ctrl(rng));
            rd(OFS_CTRL_COMPLEMENT, exp_comp(rng));
            rd(OFS_CURRENT_INV, ~top);
            check("code", drv_code, top);
            check("range", 8'(drv_range), 8'(rng));
            sample();
            check("cw", 8'(n_on >= PULSE_PERIOD_CYC - TEST_SETTLE_CYC - 1), 8'h01);
        end
        @(negedge sys_clk);
        gnd = 1;
        repeat (3) @(negedge sys_clk);
        check("fault", 8'({flag, en_n, drv_on}), 8'h06);
        gnd = 0;
        mcu.wr(OFS_CTRL_PRIMARY, 8'h4E);
        sample();
        check("latched", 8'(n_on == 0 && n_off == PULSE_PERIOD_CYC && flag), 8'h01);
        rst = 1;
        repeat (2) @(negedge sys_clk);
        rst = 0;
        check("cleared", 8'(flag), 8'h00);
        mcu.restore();
        rd(OFS_CTRL_PRIMARY, exp_ctrl(rng));
        rd(OFS_CURRENT_CODE, top);
        vdd = 1;
        for (int w = 0; w < TEST_PERIOD_CYC + 50 && flag !== 1'b1; w++)
            @(negedge sys_clk);
        check("selftest", 8'({flag, en_n, drv_on}), 8'h06);
        print_verdict();
    end
endmodule
